//--- verilog/psr_host_ctrl.sv
`timescale 1ns/10ps
// Operation
// - Chip select may be pulse or level
// - Never write strobe and output gate together
// - Select alone refreshes the addressed row
// - 256 refresh pulses every 4 ms
// - Access and refresh together need enough time
// - Row sweep by accesses also keeps data
// - Hold refresh low in standby for timer
// - Two recovery intervals after extended refresh; the code waits one, CYC_EXT_REC
// - Power-up: refresh low, others high, 100 us
// - Or initialise with 256 access cycles
// - Early write strobe timed from select fall
// - Select low maximum only for false cycles
// - Select must not glitch during address change
//
// Host side sequencer for the self-refreshing byte RAM
module psr_host_ctrl
  import psr_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic req_valid,
  input wire logic [1:0] req_kind,
  input wire logic [ADDR_W-1:0] req_addr,
  input wire logic [DATA_W-1:0] req_wdata,
  input wire logic standby,
  output logic req_ready,
  output logic done,
  output logic [DATA_W-1:0] rdata,
  output logic init_done,
  output logic ram_ce_n,
  output logic ram_oe_n,
  output logic ram_we_n,
  output logic refresh_request_n,
  output logic [ADDR_W-1:0] ram_addr,
  input wire logic [DATA_W-1:0] dq_i,
  output logic [DATA_W-1:0] dq_o,
  output logic dq_oe
);

  // ------------------------------------------------------------
  // Sub blocks
  // ------------------------------------------------------------
  psr_ref_if ref_bus ();
  logic [DATA_W-1:0] dq_sync;  // Data pins after two flops

  psr_refresh_timer u_timer (
    .clock(clock),
    .rst(rst),
    .ref_bus(ref_bus)
  );

  psr_sync u_sync (
    .clock(clock),
    .rst(rst),
    .async_in(dq_i),
    .sync_out(dq_sync)
  );

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  psr_state_t state_r;             // Sequencer state
  psr_state_t state_nxt;
  psr_kind_t kind_r;               // Kind of the cycle under way
  psr_kind_t kind_nxt;
  logic [CNT_W-1:0] cnt_r;         // Shared wait counter
  logic [CNT_W-1:0] cnt_nxt;
  logic ce_n_r;                    // Pin flops
  logic ce_n_nxt;
  logic oe_n_r;
  logic oe_n_nxt;
  logic we_n_r;
  logic we_n_nxt;
  logic ref_n_r;
  logic ref_n_nxt;
  logic [ADDR_W-1:0] addr_r;
  logic [ADDR_W-1:0] addr_nxt;
  logic [DATA_W-1:0] dq_o_r;
  logic [DATA_W-1:0] dq_o_nxt;
  logic dq_oe_r;
  logic dq_oe_nxt;
  logic ready_r;                   // User handshake flops
  logic ready_nxt;
  logic done_r;
  logic done_nxt;
  logic [DATA_W-1:0] rdata_r;
  logic [DATA_W-1:0] rdata_nxt;
  logic init_done_r;
  logic take;                      // Refresh pulse issued this cycle
  logic accept;                    // User request taken this cycle

  // Load helper for the shared counter, counts are one-based
  function automatic logic [CNT_W-1:0] wait_of(input int cyc);
    return CNT_W'(cyc - 1);
  endfunction

  assign accept = req_valid && ready_r;
  assign ref_bus.take = take;

  // ------------------------------------------------------------
  // Sequencer next values
  // ------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    kind_nxt = kind_r;
    cnt_nxt = (cnt_r == '0) ? cnt_r : cnt_r - 1'b1;
    ce_n_nxt = ce_n_r;
    oe_n_nxt = oe_n_r;
    we_n_nxt = we_n_r;
    ref_n_nxt = ref_n_r;
    addr_nxt = addr_r;
    dq_o_nxt = dq_o_r;
    dq_oe_nxt = dq_oe_r;
    done_nxt = 1'b0;
    rdata_nxt = rdata_r;
    take = 1'b0;
    unique case (state_r)
      // Refresh low, all else high; the hold is used, not sweeps
      ST_INIT: begin
        ref_n_nxt = 1'b0;
        if (ref_bus.init_done) begin
          // Held far beyond the self-timed threshold, so recover as such
          ref_n_nxt = 1'b1;
          cnt_nxt = wait_of(CYC_EXT_REC);
          state_nxt = ST_RECOV;
        end
      end
      ST_IDLE: begin
        if (accept) begin
          // Address settles a cycle before select falls
          kind_nxt = psr_kind_t'(req_kind);
          addr_nxt = req_addr;
          dq_o_nxt = req_wdata;
          state_nxt = ST_SETUP;
        end else if (ref_bus.due) begin
          take = 1'b1;
          ref_n_nxt = 1'b0;
          cnt_nxt = wait_of(CYC_REF_PW);
          state_nxt = ST_REF;
        end else if (standby) begin
          ref_n_nxt = 1'b0;
          cnt_nxt = wait_of(CYC_EXT);
          state_nxt = ST_EXT;
        end
      end
      // Select falls on a stable address
      ST_SETUP: begin
        ce_n_nxt = 1'b0;
        // Drive write data before the strobe can fall
        dq_oe_nxt = (kind_r == KIND_WRITE);
        state_nxt = ST_SELECT;
      end
      // Strobe after select so all timing counts from select
      ST_SELECT: begin
        unique case (kind_r)
          KIND_READ: begin
            oe_n_nxt = 1'b0;
            cnt_nxt = wait_of(CYC_READ);
          end
          KIND_WRITE: begin
            // Write by write strobe, after select
            we_n_nxt = 1'b0;
            cnt_nxt = wait_of(CYC_WE);
          end
          default: begin
            cnt_nxt = wait_of(CYC_CE_PW);
          end
        endcase
        state_nxt = ST_HOLD;
      end
      ST_HOLD: begin
        if (cnt_r == '0) begin
          // Select returns high as a pulse, strobes with it
          ce_n_nxt = 1'b1;
          // At most one strobe was ever low, none in a false cycle
          we_n_nxt = 1'b1;
          oe_n_nxt = 1'b1;
          if (kind_r == KIND_READ) begin
            // Sample while output gate still low
            rdata_nxt = dq_sync;
          end
          cnt_nxt = wait_of(CYC_DHOLD);
          state_nxt = ST_DRAIN;
        end
      end
      // Keep write data past the strobe fall hold time
      ST_DRAIN: begin
        if (cnt_r == '0) begin
          dq_oe_nxt = 1'b0;
          done_nxt = 1'b1;
          cnt_nxt = (kind_r == KIND_FALSE) ? wait_of(CYC_FMC_HIGH) : wait_of(CYC_CYCLE);
          state_nxt = ST_GAP;
        end
      end
      // Select high time before the next access
      ST_GAP: begin
        if (cnt_r == '0) begin
          state_nxt = ST_IDLE;
        end
      end
      // Release after the minimum low width
      ST_REF: begin
        if (cnt_r == '0) begin
          ref_n_nxt = 1'b1;
          // No select until the refresh is surely done
          cnt_nxt = wait_of(CYC_REF_CYC);
          state_nxt = ST_RECOV;
        end
      end
      // Held past 5 us so the device self-refreshes
      ST_EXT: begin
        if (cnt_r == '0 && !standby) begin
          ref_n_nxt = 1'b1;
          cnt_nxt = wait_of(CYC_EXT_REC);
          state_nxt = ST_RECOV;
        end
      end
      ST_RECOV: begin
        if (cnt_r == '0) begin
          state_nxt = ST_IDLE;
        end
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
    // Offer the bus only when idle next and not parking
    // An owed refresh closes the bus, so a request stream cannot starve it
    ready_nxt = (state_nxt == ST_IDLE) && !ref_bus.due && !(state_r == ST_IDLE && standby && !accept);
  end

  // ------------------------------------------------------------
  // Register the sequencer and pins
  // ------------------------------------------------------------
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state_r <= ST_INIT;
      kind_r <= KIND_READ;
      cnt_r <= 12'h000;
      ce_n_r <= 1'b1;
      oe_n_r <= 1'b1;
      we_n_r <= 1'b1;
      ref_n_r <= 1'b0;
      addr_r <= 13'h0000;
      dq_o_r <= 8'h00;
      dq_oe_r <= 1'b0;
      ready_r <= 1'b0;
      done_r <= 1'b0;
      rdata_r <= 8'h00;
      init_done_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      kind_r <= kind_nxt;
      cnt_r <= cnt_nxt;
      ce_n_r <= ce_n_nxt;
      oe_n_r <= oe_n_nxt;
      we_n_r <= we_n_nxt;
      ref_n_r <= ref_n_nxt;
      addr_r <= addr_nxt;
      dq_o_r <= dq_o_nxt;
      dq_oe_r <= dq_oe_nxt;
      ready_r <= ready_nxt;
      done_r <= done_nxt;
      rdata_r <= rdata_nxt;
      init_done_r <= ref_bus.init_done;
    end
  end

  // ------------------------------------------------------------
  // Outputs, all from flops
  // ------------------------------------------------------------
  assign req_ready = ready_r;
  assign done = done_r;
  assign rdata = rdata_r;
  assign init_done = init_done_r;
  assign ram_ce_n = ce_n_r;
  assign ram_oe_n = oe_n_r;
  assign ram_we_n = we_n_r;
  assign refresh_request_n = ref_n_r;
  assign ram_addr = addr_r;
  assign dq_o = dq_o_r;
  assign dq_oe = dq_oe_r;

endmodule

//--- verilog/psr_pkg.sv
package psr_pkg;

  // ------------------------------------------------------------
  // Clock and conversion
  // ------------------------------------------------------------
  localparam int CLK_NS = 40;         // Period of the 25 MHz clock

  // Least time in ns to whole cycles, rounded up, at least one
  function automatic int ns_min_cyc(input int ns);
    int c;
    c = (ns + CLK_NS - 1) / CLK_NS;
    return (c < 1) ? 1 : c;
  endfunction

  // Longest time in ns to whole cycles, rounded down, at least one
  function automatic int ns_max_cyc(input int ns);
    int c;
    c = ns / CLK_NS;
    return (c < 1) ? 1 : c;
  endfunction

  // ------------------------------------------------------------
  // Widths
  // ------------------------------------------------------------
  localparam int ADDR_W = 13;         // 8192 words
  localparam int DATA_W = 8;          // Byte wide
  localparam int CNT_W = 12;          // Shared wait counter
  localparam int SYNC_STAGES = 2;     // Read data synchroniser depth

  // ------------------------------------------------------------
  // Pin timing, slowest speed grade, in ns
  // ------------------------------------------------------------
  localparam int T_CYCLE_NS = 330;    // Access cycle time
  localparam int T_ACC_CE_NS = 200;   // Access time from chip select
  localparam int T_WE_PW_NS = 40;     // Write strobe width
  localparam int T_DHOLD_NS = 35;     // Data hold after write strobe fall
  localparam int T_CE_PW_NS = 25;     // Chip select low width
  localparam int T_FMC_HIGH_NS = 175; // Chip select high after false cycle
  localparam int T_REF_PW_NS = 30;    // Refresh request low width
  localparam int T_REF_CYC_NS = 660;  // Cycle time with a refresh
  localparam int T_EXT_NS = 5000;     // Beyond this low time refresh is self timed
  localparam int T_EXT_REC_NS = 330;  // Recovery after extended refresh
  localparam int T_INIT_NS = 100000;  // Power-up hold, 100 us
  localparam int T_WINDOW_NS = 4000000; // Refresh window, 4 ms
  localparam int REF_PER_WINDOW = 256;  // Refresh pulses per window

  // ------------------------------------------------------------
  // Derived cycle counts
  // ------------------------------------------------------------
  localparam int CYC_CYCLE = ns_min_cyc(T_CYCLE_NS);
  localparam int CYC_READ = ns_min_cyc(T_ACC_CE_NS) + SYNC_STAGES;
  localparam int CYC_WE = ns_min_cyc(T_WE_PW_NS);
  localparam int CYC_DHOLD = ns_min_cyc(T_DHOLD_NS);
  localparam int CYC_CE_PW = ns_min_cyc(T_CE_PW_NS);
  localparam int CYC_FMC_HIGH = ns_min_cyc(T_FMC_HIGH_NS);
  localparam int CYC_REF_PW = ns_min_cyc(T_REF_PW_NS);
  localparam int CYC_REF_CYC = ns_min_cyc(T_REF_CYC_NS);
  localparam int CYC_EXT = ns_min_cyc(T_EXT_NS) + 1;
  localparam int CYC_EXT_REC = ns_min_cyc(T_EXT_REC_NS);
  localparam int CYC_INIT = ns_min_cyc(T_INIT_NS);
  localparam int CYC_REF_INT = ns_max_cyc(T_WINDOW_NS / REF_PER_WINDOW);

  // ------------------------------------------------------------
  // Request kinds and controller states
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    KIND_READ = 2'h0,
    KIND_WRITE = 2'h1,
    KIND_FALSE = 2'h2
  } psr_kind_t;

  typedef enum logic [3:0] {
    ST_INIT = 4'h0,
    ST_IDLE = 4'h1,
    ST_SETUP = 4'h2,
    ST_SELECT = 4'h3,
    ST_HOLD = 4'h4,
    ST_DRAIN = 4'h5,
    ST_GAP = 4'h6,
    ST_REF = 4'h7,
    ST_EXT = 4'h8,
    ST_RECOV = 4'h9
  } psr_state_t;

endpackage

//--- verilog/psr_ref_if.sv
`timescale 1ns/10ps
// Refresh scheduling between the timer and the pin sequencer
interface psr_ref_if;
  logic due;        // Refresh owed, level until taken
  logic take;       // Sequencer issues a refresh pulse now
  logic init_done;  // Power-up hold has elapsed
  modport sched (output due, output init_done, input take);
  modport ctrl (input due, input init_done, output take);
endinterface

//--- verilog/psr_sync.sv
`timescale 1ns/10ps
// Two-stage synchroniser for the data pins
module psr_sync
  import psr_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic [DATA_W-1:0] async_in,
  output logic [DATA_W-1:0] sync_out
);

  logic [DATA_W-1:0] meta_r;  // First stage, read only by second
  logic [DATA_W-1:0] meta_nxt;
  logic [DATA_W-1:0] sync_r;  // Second stage
  logic [DATA_W-1:0] sync_nxt;

  // ------------------------------------------------------------
  // Next values
  // ------------------------------------------------------------
  always_comb begin
    meta_nxt = async_in;
    sync_nxt = meta_r;
  end

  // Register both stages
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      meta_r <= 8'h00;
      sync_r <= 8'h00;
    end else begin
      meta_r <= meta_nxt;
      sync_r <= sync_nxt;
    end
  end

  assign sync_out = sync_r;

endmodule

//--- verilog/psr_refresh_timer.sv
`timescale 1ns/10ps
// Power-up hold timer and periodic refresh scheduler
module psr_refresh_timer
  import psr_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  psr_ref_if.sched ref_bus
);

  logic [CNT_W-1:0] init_cnt_r;  // Cycles left of the power-up hold
  logic [CNT_W-1:0] init_cnt_nxt;
  logic init_done_r;
  logic init_done_nxt;
  logic [CNT_W-1:0] int_cnt_r;   // Cycles to the next owed refresh
  logic [CNT_W-1:0] int_cnt_nxt;
  logic due_r;
  logic due_nxt;

  // ------------------------------------------------------------
  // Next values
  // ------------------------------------------------------------
  always_comb begin
    init_cnt_nxt = init_cnt_r;
    init_done_nxt = init_done_r;
    int_cnt_nxt = int_cnt_r;
    due_nxt = due_r;
    if (!init_done_r) begin
      if (init_cnt_r == '0) begin
        init_done_nxt = 1'b1;
      end else begin
        init_cnt_nxt = init_cnt_r - 1'b1;
      end
    end
    if (ref_bus.take) begin
      due_nxt = 1'b0;
    end
    // One pulse per interval; a new one wins over the take
    if (init_done_r) begin
      if (int_cnt_r == '0) begin
        int_cnt_nxt = CNT_W'(CYC_REF_INT - 1);
        due_nxt = 1'b1;
      end else begin
        int_cnt_nxt = int_cnt_r - 1'b1;
      end
    end
  end

  // Register the scheduler
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      init_cnt_r <= CNT_W'(CYC_INIT - 1);
      init_done_r <= 1'b0;
      int_cnt_r <= CNT_W'(CYC_REF_INT - 1);
      due_r <= 1'b0;
    end else begin
      init_cnt_r <= init_cnt_nxt;
      init_done_r <= init_done_nxt;
      int_cnt_r <= int_cnt_nxt;
      due_r <= due_nxt;
    end
  end

  assign ref_bus.due = due_r;
  assign ref_bus.init_done = init_done_r;

endmodule

//--- verification/psr_ram_model.sv
`timescale 1ns/10ps
// Behavioural self-refreshing byte RAM at the far side of the pins
module psr_ram_model
  import psr_pkg::*;
#(
  parameter int ACC_NS = 200
)
(
  input wire logic ce_n,
  input wire logic oe_n,
  input wire logic we_n,
  input wire logic ref_n,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] din,
  output logic [DATA_W-1:0] dout,
  output logic drv,
  output logic [7:0] row_ctr,
  output logic [7:0] fmc_row,
  output logic [7:0] ext_cnt
);
  logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1]; // Array contents
  logic [ADDR_W-1:0] lat = '0; // Address held for the cycle
  logic used = 1'b0; // Cycle saw a gate or strobe
  realtime t_ce = 0.0;
  realtime t_ref = 0.0;
  initial begin
    dout = '0;
    drv = 1'b0;
    row_ctr = '0;
    fmc_row = '0;
    ext_cnt = '0;
  end
  always @(negedge ce_n) begin
    lat = addr;
    used = 1'b0;
    // A select during a running refresh starts its access when that refresh ends
    t_ce = ($realtime - t_ref < T_CYCLE_NS) ? t_ref + T_CYCLE_NS : $realtime;
  end
  always @(posedge ce_n) if (!used) fmc_row = {lat[12], lat[6:0]};
  // Data taken at strobe fall only
  always @(negedge we_n) begin
    used = 1'b1;
    mem[lat] = din;
  end
  // Drive while gate low, valid after access time
  always @(negedge oe_n) begin
    used = 1'b1;
    drv = 1'b1;
    dout = ~mem[lat];
    if ($realtime < t_ce + ACC_NS) #(t_ce + ACC_NS - $realtime);
    if (!oe_n) dout = mem[lat];
  end
  // Released bus flips, so a stale value never passes as data
  always @(posedge oe_n) begin
    drv = 1'b0;
    dout = ~dout;
  end
  // Request fall steps internal row counter
  always @(negedge ref_n) begin
    row_ctr = row_ctr + 8'h01;
    t_ref = $realtime;
  end
  // Long low request means self-timed refresh
  always @(posedge ref_n) if ($realtime - t_ref > T_EXT_NS) ext_cnt = ext_cnt + 8'h01;
endmodule

//--- verification/psr_host_ctrl_chk.sv
`timescale 1ns/10ps
// Pin sequence checks on the host controller
module psr_host_ctrl_chk
  import psr_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic req_valid,
  input wire logic [1:0] req_kind,
  input wire logic [ADDR_W-1:0] req_addr,
  input wire logic [DATA_W-1:0] req_wdata,
  input wire logic standby,
  input wire logic req_ready,
  input wire logic done,
  input wire logic [DATA_W-1:0] rdata,
  input wire logic init_done,
  input wire logic ram_ce_n,
  input wire logic ram_oe_n,
  input wire logic ram_we_n,
  input wire logic refresh_request_n,
  input wire logic [ADDR_W-1:0] ram_addr,
  input wire logic [DATA_W-1:0] dq_i,
  input wire logic [DATA_W-1:0] dq_o,
  input wire logic dq_oe
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  logic [11:0] hi_r; // Cycles refresh request high
  logic [11:0] lo_r; // Cycles select low
  logic [11:0] ini_r; // Cycles before init done
  function automatic logic [11:0] inc(input logic [11:0] v);
    return (v == 12'hFFF) ? v : v + 12'h001;
  endfunction
  // Saturating counters, so a long run never wraps
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      hi_r <= '0;
      lo_r <= '0;
      ini_r <= '0;
    end else begin
      hi_r <= refresh_request_n ? inc(hi_r) : 12'h000;
      lo_r <= ram_ce_n ? 12'h000 : inc(lo_r);
      ini_r <= init_done ? ini_r : inc(ini_r);
    end
  end
  sequence s_short_ref;
    $fell(refresh_request_n) ##1 refresh_request_n;
  endsequence
  sequence s_sel_idle;
    ram_ce_n[*8] ##1 ram_ce_n[*8];
  endsequence
  a_no_we_oe: assert property (!(ram_we_n == 1'b0 && ram_oe_n == 1'b0))
    else $error("gate and strobe low together");
  a_init_pins: assert property (!init_done |-> ram_ce_n && ram_oe_n && ram_we_n && !refresh_request_n)
    else $error("pins wrong during power-up hold");
  a_init_len: assert property ($rose(init_done) |-> ini_r >= CYC_INIT - 2)
    else $error("power-up hold too short");
  a_ref_period: assert property (hi_r <= 12'h1B8)
    else $error("refresh pulses too far apart");
  a_ext_recov: assert property ($fell(ram_ce_n) |-> hi_r >= CYC_EXT_REC)
    else $error("select too soon after refresh release");
  a_ref_to_sel: assert property (s_short_ref |-> s_sel_idle)
    else $error("select too soon after refresh pulse");
  a_oe_in_sel: assert property ($fell(ram_oe_n) |-> !ram_ce_n)
    else $error("gate fell outside a select");
  a_we_data: assert property ($fell(ram_we_n) |-> !ram_ce_n && dq_oe ##1 dq_oe && $stable(dq_o))
    else $error("write data not held over strobe fall");
  a_addr_hold: assert property ($fell(ram_ce_n) |-> $stable(ram_addr) ##1 $stable(ram_addr))
    else $error("address moved around select fall");
  a_sel_high: assert property ($rose(ram_ce_n) |-> ram_ce_n[*5])
    else $error("select high time too short");
  a_sel_max: assert property (lo_r <= 12'h0FA)
    else $error("select low too long");
  a_take_sel: assert property (req_valid && req_ready |-> ##[1:3] !ram_ce_n)
    else $error("taken request did not select");
endmodule

//--- verification/testbench.sv
`timescale 1ns/10ps
module testbench
  import psr_pkg::*;
;
  logic clock = 1'b0, rst = 1'b1, req_valid = 1'b0, standby = 1'b0;
  logic [1:0] req_kind = 2'h0;
  logic [ADDR_W-1:0] req_addr = '0;
  logic [DATA_W-1:0] req_wdata = '0;
  logic req_ready, done, init_done, dq_oe, m_drv;
  logic ram_ce_n, ram_oe_n, ram_we_n, refresh_request_n;
  logic [ADDR_W-1:0] ram_addr;
  logic [DATA_W-1:0] rdata, dq_o, dq_i, m_q;
  logic [DATA_W-1:0] bus_last = 8'h00; // Flips each cycle when undriven
  logic [7:0] row_ctr, fmc_row, ext_cnt;
  logic [ADDR_W-1:0] ad [4] = '{13'h0000, 13'h1FFF, 13'h007F, 13'h1080};
  logic [DATA_W-1:0] dat [4] = '{8'hA5, 8'h5A, 8'h3C, 8'hC3};
  int errors = 0, n_compared = 0, cyc = 0;
  // Wire level from both parties
  assign dq_i = dq_oe ? dq_o : (m_drv ? m_q : ~bus_last);
  always @(posedge clock) bus_last <= dq_i;
  always #20 clock = ~clock;
  psr_host_ctrl u_dut (.clock(clock), .rst(rst), .req_valid(req_valid), .req_kind(req_kind),
    .req_addr(req_addr), .req_wdata(req_wdata), .standby(standby), .req_ready(req_ready),
    .done(done), .rdata(rdata), .init_done(init_done), .ram_ce_n(ram_ce_n), .ram_oe_n(ram_oe_n),
    .ram_we_n(ram_we_n), .refresh_request_n(refresh_request_n), .ram_addr(ram_addr),
    .dq_i(dq_i), .dq_o(dq_o), .dq_oe(dq_oe));
  psr_ram_model u_ram (.ce_n(ram_ce_n), .oe_n(ram_oe_n), .we_n(ram_we_n), .ref_n(refresh_request_n),
    .addr(ram_addr), .din(dq_i), .dout(m_q), .drv(m_drv), .row_ctr(row_ctr), .fmc_row(fmc_row),
    .ext_cnt(ext_cnt));
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      errors++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish();
    $display("errors %0d compared %0d", errors, n_compared);
    if (errors == 0 && n_compared > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // Cut a hang short; the whole run needs well under this
  always @(posedge clock) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      tally_and_finish();
    end
  end
  // One request, held until taken, then wait for done
  task automatic do_req(input logic [1:0] k, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    int n;
    n = 0;
    req_kind = k;
    req_addr = a;
    req_wdata = d;
    req_valid = 1'b1;
    while (req_ready !== 1'b1 && n < 100) begin
      @(negedge clock);
      n++;
    end
    @(negedge clock);
    req_valid = 1'b0;
    n = 0;
    while (done !== 1'b1 && n < 60) begin
      @(negedge clock);
      n++;
    end
    check(16'(done), 16'h0001);
  endtask
  task automatic t_init();
    int n;
    n = 0;
    while (init_done !== 1'b1 && n < 3000) begin
      if (n == 100) check({ram_ce_n, ram_oe_n, ram_we_n, refresh_request_n}, 16'h000E);
      @(negedge clock);
      n++;
    end
    check(16'(n >= CYC_INIT - 2), 16'h0001);
  endtask
  task automatic t_rw();
    for (int i = 0; i < 4; i++) do_req(2'h1, ad[i], dat[i]);
    for (int i = 0; i < 4; i++) begin
      do_req(2'h0, ad[i], 8'h00);
      check(16'(rdata), 16'(dat[i]));
    end
  endtask
  task automatic t_false();
    do_req(2'h2, 13'h107F, 8'h00);
    check(16'(fmc_row), 16'h00FF);
    do_req(2'h3, 13'h0005, 8'h11);
    check(16'(fmc_row), 16'h0005);
    do_req(2'h0, 13'h0000, 8'h00);
    check(16'(rdata), 16'h00A5);
    check(16'(fmc_row), 16'h0005);
  endtask
  task automatic t_ref();
    int n;
    int c0;
    logic [7:0] r0;
    n = 0;
    c0 = cyc;
    r0 = row_ctr;
    // Back to back reads must not starve the owed refresh
    while (row_ctr === r0 && n < 30) begin
      do_req(2'h0, 13'h1FFF, 8'h00);
      check(16'(rdata), 16'h005A);
      n++;
    end
    check(16'(row_ctr), 16'(8'(r0 + 8'h01)));
    check(16'(cyc - c0 < 441), 16'h0001);
    do_req(2'h0, 13'h1FFF, 8'h00);
    check(16'(rdata), 16'h005A);
  endtask
  task automatic t_standby();
    logic [7:0] e0;
    e0 = ext_cnt;
    standby = 1'b1;
    repeat (300) @(negedge clock);
    check(16'(refresh_request_n), 16'h0000);
    standby = 1'b0;
    do_req(2'h0, 13'h007F, 8'h00);
    check(16'(rdata), 16'h003C);
    check(16'(ext_cnt), 16'(8'(e0 + 8'h01)));
  endtask
  initial begin
    repeat (8) @(negedge clock);
    rst = 1'b0;
    t_init();
    t_rw();
    t_false();
    t_ref();
    t_standby();
    tally_and_finish();
  end
endmodule

bind psr_host_ctrl psr_host_ctrl_chk u_chk (.clock(clock), .rst(rst), .req_valid(req_valid),
  .req_kind(req_kind), .req_addr(req_addr), .req_wdata(req_wdata), .standby(standby),
  .req_ready(req_ready), .done(done), .rdata(rdata), .init_done(init_done), .ram_ce_n(ram_ce_n),
  .ram_oe_n(ram_oe_n), .ram_we_n(ram_we_n), .refresh_request_n(refresh_request_n),
  .ram_addr(ram_addr), .dq_i(dq_i), .dq_o(dq_o), .dq_oe(dq_oe));
